// ==== src/gpese_top.sv ====
`timescale 1ns/1ps
`include "gpese_regs.svh"
module gpese_top (
  // Clock and reset.
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // I/O register port, offset relative to the power management base.
  input  wire logic [7:0]  io_addr_in,
  input  wire logic        io_wr_in,
  input  wire logic        io_rd_in,
  input  wire logic [1:0]  io_be_in,
  input  wire logic [15:0] io_wdata_in,
  output logic      [15:0] io_rdata_out,
  output logic             io_ack_out,
  // Event pins from outside the clock domain.
  input  wire logic        lid_in,
  input  wire logic        ring_indicate_n_in,
  input  wire logic        gp_input1_n_in,
  input  wire logic        thermal_alarm_n_in,
  // Same-domain event pulses and settings.
  input  wire logic        usb_resume_in,
  input  wire logic        thermal_override_start_in,
  input  wire logic        lid_polarity_in,
  input  wire logic        thermal_polarity_in,
  input  wire logic        os_control_interrupt_enable_in,
  input  wire logic        suspended_in,
  // Generated events.
  output logic             os_control_interrupt_out,
  output logic             management_interrupt_n_out,
  output logic             resume_event_out
);

  logic [3:0]                 pin_sync;
  logic                       lid_asserted;
  logic                       ring_asserted;
  logic                       gpi_asserted;
  logic                       therm_asserted;
  logic                       lid_prev_ff;
  logic                       ring_prev_ff;
  logic                       gpi_prev_ff;
  logic                       therm_prev_ff;
  gpese_pkg::gpese_word_t     set_vec;
  gpese_pkg::gpese_word_t     clr_vec;
  gpese_pkg::gpese_word_t     status;
  gpese_pkg::gpese_word_t     enable_ff;
  gpese_pkg::gpese_word_t     nxt_enable;
  gpese_pkg::gpese_word_t     lane_mask;
  gpese_pkg::gpese_word_t     pending;
  gpese_pkg::gpese_word_t     both_vec;
  gpese_pkg::gpese_route_e    route;
  logic                       sts_hit;
  logic                       en_hit;
  logic                       nxt_os_int;
  logic                       nxt_mgmt_int;
  logic                       nxt_resume;

  // Pins are brought into the clock domain before anything looks at them.
  gpese_sync #(
    .W (4)
  ) u_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .async_in   ({thermal_alarm_n_in, gp_input1_n_in, ring_indicate_n_in, lid_in}),
    .sync_out   (pin_sync)
  );

  // Polarity selects which level of the lid and thermal pins counts as asserted.
  always_comb
  begin
    lid_asserted  = lid_polarity_in ? pin_sync[0] : ~pin_sync[0];
    ring_asserted = ~pin_sync[1];
    gpi_asserted  = ~pin_sync[2];
    therm_asserted = thermal_polarity_in ? pin_sync[3] : ~pin_sync[3];
  end

  // Flags capture the moment of assertion. Changing a polarity setting can
  // itself look like an assertion, so software should clear flags afterwards.
  // The history leaves reset as asserted: the synchronisers come out of reset
  // at zero, which reads as asserted for the active-low pins, and that must not
  // pass for an event. An active-low pin asserted across reset is caught on its next edge; an active-high one sets its flag as the synchroniser fills.
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      lid_prev_ff   <= 1'b1;
      ring_prev_ff  <= 1'b1;
      gpi_prev_ff   <= 1'b1;
      therm_prev_ff <= 1'b1;
    end
    else
    begin
      lid_prev_ff   <= lid_asserted;
      ring_prev_ff  <= ring_asserted;
      gpi_prev_ff   <= gpi_asserted;
      therm_prev_ff <= therm_asserted;
    end
  end

  // Set conditions do not look at the enables at all.
  always_comb
  begin
    set_vec                   = 16'h0000;
    set_vec[`GPESE_BIT_LID]  = lid_asserted & ~lid_prev_ff;
    set_vec[`GPESE_BIT_RING] = ring_asserted & ~ring_prev_ff;
    set_vec[`GPESE_BIT_GPI]  = gpi_asserted & ~gpi_prev_ff;
    set_vec[`GPESE_BIT_USB]  = usb_resume_in & suspended_in;
    set_vec[`GPESE_BIT_THOR] = thermal_override_start_in;
    set_vec[`GPESE_BIT_THERM] = therm_asserted & ~therm_prev_ff;
  end

  // Register decode.
  always_comb
  begin
    sts_hit   = (io_addr_in == `GPESE_STS_OFS);
    en_hit    = (io_addr_in == `GPESE_EN_OFS);
    lane_mask = {{8{io_be_in[1]}}, {8{io_be_in[0]}}};
  end

  // A one written to a status bit clears it; a zero leaves it alone.
  always_comb
  begin
    if (io_wr_in && sts_hit)
      clr_vec = io_wdata_in & lane_mask & `GPESE_STS_MASK;
    else
      clr_vec = 16'h0000;
  end

  // The flag bank is kept apart so that the set-over-clear order sits in one place.
  gpese_flag_bank #(
    .W (16)
  ) u_flags (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .set_in     (set_vec & `GPESE_STS_MASK),
    .clr_in     (clr_vec),
    .flag_out   (status)
  );

  always_comb
  begin
    nxt_enable = enable_ff;
    if (io_wr_in && en_hit)
      nxt_enable = ((enable_ff & ~lane_mask) | (io_wdata_in & lane_mask))
                   & `GPESE_EN_MASK;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      enable_ff <= `GPESE_EN_RST;
    else
      enable_ff <= nxt_enable;
  end

  // Reads answer one cycle later; unmapped offsets return zero without ack.
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      io_rdata_out <= 16'h0000;
      io_ack_out   <= 1'b0;
    end
    else
    begin
      io_ack_out <= (io_rd_in | io_wr_in) & (sts_hit | en_hit);
      if (io_rd_in && sts_hit)
        io_rdata_out <= status & `GPESE_STS_MASK;
      else if (io_rd_in && en_hit)
        io_rdata_out <= enable_ff;
      else
        io_rdata_out <= 16'h0000;
    end
  end

  // While suspended, events wake the system; otherwise the global enable
  // picks the OS interrupt over the management interrupt.
  always_comb
  begin
    if (suspended_in)
      route = gpese_pkg::GPESE_ROUTE_RESUME;
    else if (os_control_interrupt_enable_in)
      route = gpese_pkg::GPESE_ROUTE_OS;
    else
      route = gpese_pkg::GPESE_ROUTE_MGMT;
  end

  // Only lid, general input and thermal can interrupt; ring and USB cannot.
  always_comb
  begin
    pending    = status & enable_ff & `GPESE_INT_SRC_MASK;
    nxt_os_int   = 1'b0;
    nxt_mgmt_int = 1'b0;
    nxt_resume   = 1'b0;
    case (route)
      gpese_pkg::GPESE_ROUTE_OS:
        nxt_os_int = |pending;
      gpese_pkg::GPESE_ROUTE_MGMT:
        nxt_mgmt_int = |pending;
      gpese_pkg::GPESE_ROUTE_RESUME:
        nxt_resume = |(set_vec & enable_ff & `GPESE_RES_SRC_MASK);
      default:
        nxt_os_int = 1'b0;
    endcase
  end

  // The interrupts are levels held while an enabled flag stays set.
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      os_control_interrupt_out   <= 1'b0;
      management_interrupt_n_out <= 1'b1;
      resume_event_out           <= 1'b0;
    end
    else
    begin
      os_control_interrupt_out   <= nxt_os_int;
      management_interrupt_n_out <= ~nxt_mgmt_int;
      resume_event_out           <= nxt_resume;
    end
  end

  assign both_vec = set_vec & clr_vec;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  // Expectations below come from the register map and the routing rules, so
  // they keep watch even where the bench does not look.

  a_lid_sets_flag: assert property (
    set_vec[`GPESE_BIT_LID] |=> status[`GPESE_BIT_LID])
    else $error("lid assertion did not set its flag");

  a_set_beats_clear: assert property (
    (both_vec != 16'h0000) |=> ((status & $past(both_vec)) == $past(both_vec)))
    else $error("clear swallowed a same-cycle set");

  a_clear_by_one: assert property (
    (clr_vec[`GPESE_BIT_GPI] && !set_vec[`GPESE_BIT_GPI])
      |=> !status[`GPESE_BIT_GPI])
    else $error("writing one did not clear the flag");

  a_zero_keeps_flag: assert property (
    (io_wr_in && sts_hit && status[`GPESE_BIT_USB] && !io_wdata_in[`GPESE_BIT_USB])
      |=> status[`GPESE_BIT_USB])
    else $error("writing zero changed a flag");

  a_reserved_zero: assert property (
    ((status & ~`GPESE_STS_MASK) == 16'h0000)
      && ((enable_ff & ~`GPESE_EN_MASK) == 16'h0000))
    else $error("reserved bit became set");

  a_ring_resume_only: assert property (
    (suspended_in && set_vec[`GPESE_BIT_RING] && enable_ff[`GPESE_BIT_RING])
      |=> resume_event_out)
    else $error("enabled ring event gave no resume");

  a_usb_resume: assert property (
    (suspended_in && set_vec[`GPESE_BIT_USB] && enable_ff[`GPESE_BIT_USB])
      |=> resume_event_out ##1 !resume_event_out[*1])
    else $error("usb wake did not give a one-cycle resume");

  a_os_int_gated: assert property (
    os_control_interrupt_out |-> $past(os_control_interrupt_enable_in)
      && !$past(suspended_in))
    else $error("OS interrupt without global enable");

  a_therm_no_resume: assert property (
    ((set_vec & `GPESE_RES_SRC_MASK) == 16'h0000)
      |=> !resume_event_out)
    else $error("resume without a wake source being set");

  a_lid_interrupts: assert property (
    (status[`GPESE_BIT_LID] && enable_ff[`GPESE_BIT_LID] && !suspended_in
      && !os_control_interrupt_enable_in)
      |=> !management_interrupt_n_out)
    else $error("enabled lid flag gave no management interrupt");

  a_enable_blocks: assert property (
    ((status & enable_ff & `GPESE_INT_SRC_MASK) == 16'h0000)
      |=> (os_control_interrupt_out == 1'b0) && management_interrupt_n_out)
    else $error("interrupt raised with no enabled flag");

  a_override_sets: assert property (
    thermal_override_start_in |=> status[`GPESE_BIT_THOR] [*1])
    else $error("thermal override did not set its flag");

  a_ring_pin_sets: assert property (
    $fell(pin_sync[1]) |=> status[`GPESE_BIT_RING])
    else $error("ring indicate assertion did not set its flag");

  a_gpi_pin_sets: assert property (
    $fell(pin_sync[2]) |=> status[`GPESE_BIT_GPI])
    else $error("general input assertion did not set its flag");

  a_usb_needs_suspend: assert property (
    (usb_resume_in && !suspended_in && !status[`GPESE_BIT_USB])
      |=> !status[`GPESE_BIT_USB])
    else $error("usb resume set its flag while awake");

  a_gpi_interrupts: assert property (
    (status[`GPESE_BIT_GPI] && enable_ff[`GPESE_BIT_GPI] && !suspended_in
      && os_control_interrupt_enable_in)
      |=> os_control_interrupt_out)
    else $error("enabled input flag gave no OS interrupt");

  a_ack_on_hit: assert property (
    ((io_rd_in || io_wr_in) && (sts_hit || en_hit)) |=> io_ack_out)
    else $error("mapped access got no acknowledge");

  a_unmapped_quiet: assert property (
    ((io_rd_in || io_wr_in) && !sts_hit && !en_hit)
      |=> !io_ack_out && (io_rdata_out == 16'h0000))
    else $error("unmapped access was answered");

  a_enable_write: assert property (
    (io_wr_in && en_hit && (io_be_in == 2'h3))
      |=> (enable_ff == ($past(io_wdata_in) & `GPESE_EN_MASK)))
    else $error("enable write did not land");

  a_mgmt_gated: assert property (
    !management_interrupt_n_out |-> !$past(os_control_interrupt_enable_in)
      && !$past(suspended_in))
    else $error("management interrupt while OS interrupt enabled");

  a_flag_needs_set: assert property (
    (set_vec == 16'h0000) |=> ((status & ~$past(status)) == 16'h0000))
    else $error("flag rose with no hardware set");

  // Scenarios worth seeing at least once.

  c_lid_to_os: cover property (
    set_vec[`GPESE_BIT_LID] ##1 status[`GPESE_BIT_LID] ##1 os_control_interrupt_out);

  c_ring_resume: cover property (
    set_vec[`GPESE_BIT_RING] && suspended_in ##1 resume_event_out);

  c_set_clear_clash: cover property (both_vec != 16'h0000);

  c_gpi_mgmt: cover property (
    status[`GPESE_BIT_GPI] ##1 !management_interrupt_n_out);

  c_usb_resume: cover property (
    set_vec[`GPESE_BIT_USB] ##1 resume_event_out);

endmodule

// ==== src/gpese_regs.svh ====
`ifndef GPESE_REGS_SVH
`define GPESE_REGS_SVH

`define GPESE_STS_OFS      8'h0c
`define GPESE_EN_OFS       8'h0e
`define GPESE_STS_RST      16'h0000
`define GPESE_EN_RST       16'h0000
`define GPESE_STS_MASK     16'h0f81
`define GPESE_EN_MASK      16'h0f01
`define GPESE_INT_SRC_MASK 16'h0a01
`define GPESE_RES_SRC_MASK 16'h0f00
`define GPESE_BIT_LID      11
`define GPESE_BIT_RING     10
`define GPESE_BIT_GPI      9
`define GPESE_BIT_USB      8
`define GPESE_BIT_THOR     7
`define GPESE_BIT_THERM    0

`endif

// ==== src/gpese_pkg.sv ====
package gpese_pkg;

  typedef logic [15:0] gpese_word_t;

  typedef enum logic [1:0]
  {
    GPESE_ROUTE_OS,
    GPESE_ROUTE_MGMT,
    GPESE_ROUTE_RESUME
  } gpese_route_e;

endpackage

// ==== src/gpese_sync.sv ====
`timescale 1ns/1ps
module gpese_sync #(
  parameter int W = 4
) (
  // Clock and reset.
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  // Asynchronous levels in, synchronised levels out.
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge sys_clk_in)
      begin
        if (rst_in)
        begin
          meta_ff[i]  <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else
        begin
          meta_ff[i]  <= async_in[i];
          sync_out[i] <= meta_ff[i];
        end
      end
    end
  endgenerate

endmodule

// ==== src/gpese_flag_bank.sv ====
`timescale 1ns/1ps
module gpese_flag_bank #(
  parameter int W = 16
) (
  // Clock and reset.
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  // Per-bit set and clear requests.
  input  wire logic [W-1:0] set_in,
  input  wire logic [W-1:0] clr_in,
  // Sticky flags.
  output logic      [W-1:0] flag_out
);

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_flag
      // The set term is tested first so a clear never swallows a new event.
      always_ff @(posedge sys_clk_in)
      begin
        if (rst_in)
          flag_out[i] <= 1'b0;
        else if (set_in[i])
          flag_out[i] <= 1'b1;
        else if (clr_in[i])
          flag_out[i] <= 1'b0;
      end
    end
  endgenerate

endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`include "gpese_regs.svh"
module tb_top;
  logic        sys_clk_in                     = 1'b0;
  logic        rst_in                         = 1'b1;
  logic [7:0]  io_addr_in                     = 8'h00;
  logic        io_wr_in                       = 1'b0;
  logic        io_rd_in                       = 1'b0;
  logic [1:0]  io_be_in                       = 2'h3;
  logic [15:0] io_wdata_in                    = 16'h0000;
  logic [15:0] io_rdata_out;
  logic        io_ack_out;
  logic        lid_in                         = 1'b0;
  logic        ring_indicate_n_in             = 1'b1;
  logic        gp_input1_n_in                 = 1'b1;
  logic        thermal_alarm_n_in             = 1'b1;
  logic        usb_resume_in                  = 1'b0;
  logic        thermal_override_start_in      = 1'b0;
  logic        lid_polarity_in                = 1'b1;
  logic        thermal_polarity_in            = 1'b0;
  logic        os_control_interrupt_enable_in = 1'b1;
  logic        suspended_in                   = 1'b0;
  logic        os_control_interrupt_out;
  logic        management_interrupt_n_out;
  logic        resume_event_out;
  int          n_errors                       = 0;
  int          total_checks                   = 0;
  int          n_resume                       = 0;

  gpese_top dut_u (
    .sys_clk_in                     (sys_clk_in),
    .rst_in                         (rst_in),
    .io_addr_in                     (io_addr_in),
    .io_wr_in                       (io_wr_in),
    .io_rd_in                       (io_rd_in),
    .io_be_in                       (io_be_in),
    .io_wdata_in                    (io_wdata_in),
    .io_rdata_out                   (io_rdata_out),
    .io_ack_out                     (io_ack_out),
    .lid_in                         (lid_in),
    .ring_indicate_n_in             (ring_indicate_n_in),
    .gp_input1_n_in                 (gp_input1_n_in),
    .thermal_alarm_n_in             (thermal_alarm_n_in),
    .usb_resume_in                  (usb_resume_in),
    .thermal_override_start_in      (thermal_override_start_in),
    .lid_polarity_in                (lid_polarity_in),
    .thermal_polarity_in            (thermal_polarity_in),
    .os_control_interrupt_enable_in (os_control_interrupt_enable_in),
    .suspended_in                   (suspended_in),
    .os_control_interrupt_out       (os_control_interrupt_out),
    .management_interrupt_n_out     (management_interrupt_n_out),
    .resume_event_out               (resume_event_out)
  );

  initial
  begin
    forever #50 sys_clk_in = ~sys_clk_in;
  end

  // Resume is a one-cycle pulse, so it is counted at every edge rather than sampled late.
  always @(posedge sys_clk_in)
  begin
    if (resume_event_out === 1'b1)
      n_resume <= n_resume + 1;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  // One strobe cycle; the answer stands for the cycle after the strobe edge and is
  // taken at the edge that closes that cycle, so every input moves on an edge.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
                     output logic [15:0] q, output logic k);
    @(posedge sys_clk_in);
    io_addr_in  <= a;
    io_wr_in    <= wr;
    io_rd_in    <= !wr;
    io_wdata_in <= d;
    @(posedge sys_clk_in);
    io_wr_in <= 1'b0;
    io_rd_in <= 1'b0;
    @(posedge sys_clk_in);
    q = io_rdata_out;
    k = io_ack_out;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    logic        k;
    bus(1'b1, a, d, q, k);
    chk("write ack", 16'h0001, {15'h0000, k});
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] q;
    logic        k;
    bus(1'b0, a, 16'h0000, q, k);
    chk("read ack", 16'h0001, {15'h0000, k});
    chk(what, exp, q);
  endtask

  task automatic chk_irq(input logic os, input logic mgmt_n);
    chk("os interrupt", {15'h0000, os}, {15'h0000, os_control_interrupt_out});
    chk("mgmt interrupt_n", {15'h0000, mgmt_n}, {15'h0000, management_interrupt_n_out});
  endtask

  task automatic t_regs();
    logic [15:0] q;
    logic        k;
    rd("status reset", `GPESE_STS_OFS, 16'h0000);
    rd("enable reset", `GPESE_EN_OFS, 16'h0000);
    bus(1'b0, 8'h10, 16'h0000, q, k);
    chk("unmapped ack", 16'h0000, {15'h0000, k});
    chk("unmapped data", 16'h0000, q);
    wr(`GPESE_EN_OFS, 16'hffff);
    rd("enable reserved", `GPESE_EN_OFS, 16'h0f01);
    io_be_in <= 2'h1;
    wr(`GPESE_EN_OFS, 16'h0000);
    io_be_in <= 2'h3;
    rd("enable low lane", `GPESE_EN_OFS, 16'h0f00);
    wr(`GPESE_STS_OFS, 16'hffff);
    rd("status untouched", `GPESE_STS_OFS, 16'h0000);
  endtask

  task automatic t_ring();
    suspended_in <= 1'b1;
    wr(`GPESE_EN_OFS, 16'h0400);
    n_resume = 0;
    ring_indicate_n_in <= 1'b0;
    step(6);
    rd("ring flag", `GPESE_STS_OFS, 16'h0400);
    chk("ring resume", 16'h0001, n_resume[15:0]);
    chk_irq(1'b0, 1'b1);
    ring_indicate_n_in <= 1'b1;
    wr(`GPESE_STS_OFS, 16'h0000);
    rd("zero write keeps", `GPESE_STS_OFS, 16'h0400);
    wr(`GPESE_STS_OFS, 16'h0400);
    rd("one write clears", `GPESE_STS_OFS, 16'h0000);
    suspended_in <= 1'b0;
  endtask

  task automatic t_gpi();
    wr(`GPESE_EN_OFS, 16'h0200);
    gp_input1_n_in <= 1'b0;
    step(6);
    rd("input flag", `GPESE_STS_OFS, 16'h0200);
    chk_irq(1'b1, 1'b1);
    os_control_interrupt_enable_in <= 1'b0;
    step(3);
    chk_irq(1'b0, 1'b0);
    wr(`GPESE_EN_OFS, 16'h0000);
    step(3);
    chk_irq(1'b0, 1'b1);
    os_control_interrupt_enable_in <= 1'b1;
    gp_input1_n_in <= 1'b1;
    wr(`GPESE_STS_OFS, 16'h0200);
  endtask

  task automatic t_lid();
    lid_in <= 1'b1;
    step(6);
    rd("lid flag", `GPESE_STS_OFS, 16'h0800);
    chk_irq(1'b0, 1'b1);
    wr(`GPESE_EN_OFS, 16'h0800);
    step(3);
    chk_irq(1'b1, 1'b1);
    os_control_interrupt_enable_in <= 1'b0;
    step(3);
    chk_irq(1'b0, 1'b0);
    os_control_interrupt_enable_in <= 1'b1;
    wr(`GPESE_STS_OFS, 16'h0800);
    step(3);
    chk_irq(1'b0, 1'b1);
    rd("lid held no reset", `GPESE_STS_OFS, 16'h0000);
    lid_polarity_in <= 1'b0;
    step(3);
    lid_in <= 1'b0;
    step(6);
    rd("lid low polarity", `GPESE_STS_OFS, 16'h0800);
    lid_polarity_in <= 1'b1;
    wr(`GPESE_STS_OFS, 16'h0800);
  endtask

  task automatic t_thermal();
    wr(`GPESE_EN_OFS, 16'h0001);
    thermal_alarm_n_in <= 1'b0;
    step(6);
    rd("thermal flag", `GPESE_STS_OFS, 16'h0001);
    chk_irq(1'b1, 1'b1);
    thermal_polarity_in <= 1'b1;
    wr(`GPESE_STS_OFS, 16'h0001);
    rd("thermal polarity swap", `GPESE_STS_OFS, 16'h0000);
    suspended_in <= 1'b1;
    n_resume = 0;
    thermal_alarm_n_in <= 1'b1;
    step(6);
    rd("thermal high polarity", `GPESE_STS_OFS, 16'h0001);
    chk("thermal no resume", 16'h0000, n_resume[15:0]);
    chk_irq(1'b0, 1'b1);
    thermal_polarity_in <= 1'b0;
    suspended_in <= 1'b0;
    wr(`GPESE_STS_OFS, 16'h0001);
  endtask

  task automatic t_usb();
    wr(`GPESE_EN_OFS, 16'h0100);
    usb_resume_in <= 1'b1;
    step(1);
    usb_resume_in <= 1'b0;
    step(3);
    rd("usb awake ignored", `GPESE_STS_OFS, 16'h0000);
    suspended_in <= 1'b1;
    n_resume = 0;
    step(1);
    usb_resume_in <= 1'b1;
    step(1);
    usb_resume_in <= 1'b0;
    step(3);
    rd("usb flag", `GPESE_STS_OFS, 16'h0100);
    chk("usb resume", 16'h0001, n_resume[15:0]);
    wr(`GPESE_STS_OFS, 16'h0100);
    suspended_in <= 1'b0;
    fork
      wr(`GPESE_STS_OFS, 16'h0080);
      begin
        @(posedge sys_clk_in);
        thermal_override_start_in <= 1'b1;
        @(posedge sys_clk_in);
        thermal_override_start_in <= 1'b0;
      end
    join
    rd("set beats clear", `GPESE_STS_OFS, 16'h0080);
    wr(`GPESE_STS_OFS, 16'h0080);
    rd("override cleared", `GPESE_STS_OFS, 16'h0000);
  endtask

  initial
  begin
    step(4);
    rst_in <= 1'b0;
    step(3);
    t_regs();
    t_ring();
    t_gpi();
    t_lid();
    t_thermal();
    t_usb();
    report_and_stop();
  end

  // A hung handshake would otherwise stall the run forever.
  initial
  begin
    step(5000);
    n_errors++;
    $display("BAD watchdog expected finish seen timeout");
    report_and_stop();
  end
endmodule
